// ==== rtl/amtc_pkg.sv ====
// Constants for the modulator and test configuration registers.
// Assumes a 40 MHz clock, a 400 kHz control clock and an external serial front end.
package amtc_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int          CLK_HZ          = 40_000_000;
   localparam int          PWM_55K_HZ      = 55_000;
   localparam int          PWM_110K_HZ     = 110_000;
   localparam int          PWM_220K_HZ     = 220_000;
   localparam logic [9:0]  PWM_DIV_55K     = 10'(CLK_HZ / PWM_55K_HZ);
   localparam logic [9:0]  PWM_DIV_110K    = 10'(CLK_HZ / PWM_110K_HZ);
   localparam logic [9:0]  PWM_DIV_220K    = 10'(CLK_HZ / PWM_220K_HZ);
   localparam int          CTRL_CLK_HZ     = 400_000;
   localparam int          FAST_FACTOR     = 100;
   localparam logic [9:0]  CTRL_DIV        = 10'(CLK_HZ / CTRL_CLK_HZ);
   localparam logic [9:0]  CTRL_DIV_FAST   = 10'(CLK_HZ / CTRL_CLK_HZ / FAST_FACTOR);
   localparam logic [2:0]  STRAP_SETTLE    = 3'h5;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [4:0]  MOD_CFG_ADDR    = 5'h05;
   localparam logic [4:0]  TEST_CFG_ADDR   = 5'h06;
   localparam int          MOD_SHUNT_BIT   = 0;
   localparam int          MOD_GAIN_HI_BIT = 2;
   localparam int          MOD_DAC_SYNC_BIT= 3;
   localparam int          MOD_SVR_BIT     = 4;
   localparam int          MOD_TRI_BIT     = 5;
   localparam int          MOD_RATE_LSB    = 6;
   localparam int          TST_ZC_BIT      = 0;
   localparam int          TST_RAMP_BIT    = 1;
   localparam int          TST_GATE_BIT    = 2;
   localparam int          TST_FAST_BIT    = 3;
   localparam logic [7:0]  MOD_MASK        = 8'hFD;
   localparam logic [7:0]  TEST_MASK       = 8'h0F;
   localparam logic [7:0]  MOD_RST_SERIAL  = 8'h41;
   localparam logic [7:0]  MOD_RST_STRAP   = 8'h60;
   localparam logic [7:0]  TEST_RST        = 8'h00;

   // Strap and settle sequence
   typedef enum logic [0:0] {ST_SETTLE, ST_RUN} amtc_state_e;

   // Switching period in clock cycles for a rate select code
   function automatic logic [9:0] rate_div(input logic [1:0] sel);
      case (sel)
         2'h0:    rate_div = PWM_DIV_55K;
         2'h2:    rate_div = PWM_DIV_220K;
         default: rate_div = PWM_DIV_110K;
      endcase
   endfunction

endpackage

// ==== rtl/amtc_tick_gen.sv ====
// Programmable divider giving a one-cycle enable pulse.
// Assumes period is at least 1; a new period applies at the next reload.
`timescale 1ns/10ps
module amtc_tick_gen #(
   parameter int WIDTH = 10
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] period,
   output logic                  tick
);

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic             tick_q;
   logic             tick_d;

   // ****************************************************************
   // Down counter with reload
   // ****************************************************************
   always_comb begin
      tick_d = (cnt_q == '0);
      cnt_d  = tick_d ? period - WIDTH'(1) : cnt_q - WIDTH'(1);
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule // amtc_tick_gen

// ==== rtl/amtc_config_regs.sv ====
// Modulator and test configuration registers with strap loading.
// Assumes a serial front end giving subaddress, write and read strobes.
`timescale 1ns/10ps

// Summary of operation
// - Top two modulator bits pick PWM rate
// - Bit 3 locks modulator timing to DAC
// - Bit 4 turns on reference charging
// - Upper gain bit is modulator bit 2
// - Two gain bits pick four input gains
// - Gain bits load from strap pins at power-up
// - Test bit 0 puts XNOR terms on clip
// - Test bit 1 ramps compressor gain
// - Test bit 2 bypasses gate drive limit
// - Test bit 3 divides time constants by 100
// - Tristate fast mutes; leaving gives fast unmute
module amtc_config_regs
   import amtc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [4:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       gain_hi_strap_pin,
   input  wire logic       gain_lo_strap_pin,
   input  wire logic       serial_mode_pin,
   input  wire logic       neg_input_level,
   input  wire logic       pos_input_level,
   input  wire logic       neg_output_level,
   input  wire logic       pos_output_level,
   input  wire logic       clip_normal,
   input  wire logic [4:0] comp_gain_normal,
   output logic      [1:0] pwm_rate_select,
   output logic            pwm_tick,
   output logic            modulator_tristate,
   output logic            dac_sync,
   output logic            mid_supply_reference,
   output logic            shunt_on,
   output logic            gain_select_hi,
   output logic            gain_select_lo,
   output logic            zero_cross_debug_out,
   output logic      [4:0] comp_gain,
   output logic            gate_drive_limit_bypass,
   output logic            fast_time,
   output logic            ctrl_tick,
   output logic            mute_fast_discharge,
   output logic            unmute_fast
);

   // ****************************************************************
   // Pin synchronisers, three stages with agreement filter
   // ****************************************************************
   logic [6:0] pin_in;
   logic [6:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   assign pin_in = {pos_output_level, neg_output_level, pos_input_level, neg_input_level,
                    serial_mode_pin, gain_lo_strap_pin, gain_hi_strap_pin};
   // Accept a change once stages two and three agree
   always_comb begin
      filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q   <= 7'h00;
         s2_q   <= 7'h00;
         s3_q   <= 7'h00;
         filt_q <= 7'h00;
      end else begin
         s1_q   <= pin_in;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   // ****************************************************************
   // Register file and strap load
   // ****************************************************************
   amtc_state_e st_q, st_d;
   logic [2:0]  cnt_q, cnt_d;
   logic [7:0]  mod_q, mod_d, test_q, test_d, rdata_q, rdata_d;
   logic        gain_lo_q, gain_lo_d, unmute_q, unmute_d;
   logic        clip_q, clip_d, wr_ok;
   logic [4:0]  comp_q, comp_d;
   assign wr_ok = reg_wr && (st_q == ST_RUN);
   // Next register state
   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      mod_d     = mod_q;
      test_d    = test_q;
      gain_lo_d = gain_lo_q;
      rdata_d   = rdata_q;
      case (st_q)
         ST_SETTLE: begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == STRAP_SETTLE) begin
               st_d  = ST_RUN;
               mod_d = filt_q[2] ? MOD_RST_SERIAL : MOD_RST_STRAP;
               mod_d[MOD_GAIN_HI_BIT] = filt_q[0];
               gain_lo_d = filt_q[1];
            end
         end
         ST_RUN: begin
            if (wr_ok && reg_addr == MOD_CFG_ADDR) begin
               mod_d = reg_wdata & MOD_MASK;
            end
            if (wr_ok && reg_addr == TEST_CFG_ADDR) begin
               test_d = reg_wdata & TEST_MASK;
            end
         end
         default: st_d = ST_SETTLE;
      endcase
      if (reg_rd) begin
         case (reg_addr)
            MOD_CFG_ADDR:  rdata_d = mod_q & MOD_MASK;
            TEST_CFG_ADDR: rdata_d = test_q & TEST_MASK;
            default:       rdata_d = 8'h00;
         endcase
      end
   end
   // Leaving tristate gives a one-cycle fast unmute pulse
   always_comb begin
      unmute_d = mod_q[MOD_TRI_BIT] & ~mod_d[MOD_TRI_BIT];
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q      <= ST_SETTLE;
         cnt_q     <= 3'h0;
         mod_q     <= MOD_RST_SERIAL;
         test_q    <= TEST_RST;
         gain_lo_q <= 1'b0;
         rdata_q   <= 8'h00;
         unmute_q  <= 1'b0;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         mod_q     <= mod_d;
         test_q    <= test_d;
         gain_lo_q <= gain_lo_d;
         rdata_q   <= rdata_d;
         unmute_q  <= unmute_d;
      end
   end

   // ****************************************************************
   // Rate dividers
   // ****************************************************************
   logic [9:0] pwm_period, ctrl_period;
   // Switching rate and control time base
   always_comb begin
      pwm_period  = rate_div(mod_q[MOD_RATE_LSB +: 2]);
      ctrl_period = test_q[TST_FAST_BIT] ? CTRL_DIV_FAST : CTRL_DIV;
   end

   amtc_tick_gen #(.WIDTH(10)) u_pwm_tick (
      .clk    (clk),
      .srst   (srst),
      .period (pwm_period),
      .tick   (pwm_tick)
   );
   amtc_tick_gen #(.WIDTH(10)) u_ctrl_tick (
      .clk    (clk),
      .srst   (srst),
      .period (ctrl_period),
      .tick   (ctrl_tick)
   );

   // ****************************************************************
   // Clip output and compressor gain
   // ****************************************************************
   always_comb begin
      clip_d = clip_normal;
      if (test_q[TST_ZC_BIT]) begin
         clip_d = (filt_q[3] ~^ filt_q[4]) | (filt_q[5] ~^ filt_q[6]);
      end
      comp_d = comp_gain_normal;
      if (test_q[TST_RAMP_BIT]) begin
         comp_d = ctrl_tick ? comp_q + 5'h01 : comp_q;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         clip_q <= 1'b0;
         comp_q <= 5'h00;
      end else begin
         clip_q <= clip_d;
         comp_q <= comp_d;
      end
   end
   // Outputs straight from register bits
   assign reg_rdata               = rdata_q;
   assign pwm_rate_select         = mod_q[MOD_RATE_LSB +: 2];
   assign modulator_tristate      = mod_q[MOD_TRI_BIT];
   assign mute_fast_discharge     = mod_q[MOD_TRI_BIT];
   assign unmute_fast             = unmute_q;
   assign dac_sync                = mod_q[MOD_DAC_SYNC_BIT];
   assign mid_supply_reference    = mod_q[MOD_SVR_BIT];
   assign shunt_on                = mod_q[MOD_SHUNT_BIT];
   assign gain_select_hi          = mod_q[MOD_GAIN_HI_BIT];
   assign gain_select_lo          = gain_lo_q;
   assign zero_cross_debug_out    = clip_q;
   assign comp_gain               = comp_q;
   assign gate_drive_limit_bypass = test_q[TST_GATE_BIT];
   assign fast_time               = test_q[TST_FAST_BIT];

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [9:0] gap_q;
   logic [1:0] sel_prev_q;
   logic       seen_q, dirty_q, sel_chg;
   assign sel_chg = (sel_prev_q != pwm_rate_select);
   // Cycles between switching ticks, flagged if rate moved
   always_ff @(posedge clk) begin
      if (srst) begin
         gap_q      <= 10'h000;
         sel_prev_q <= 2'h0;
         seen_q     <= 1'b0;
         dirty_q    <= 1'b1;
      end else begin
         gap_q      <= pwm_tick ? 10'h000 : gap_q + 10'h001;
         sel_prev_q <= pwm_rate_select;
         seen_q     <= seen_q | pwm_tick;
         dirty_q    <= pwm_tick ? sel_chg : (dirty_q | sel_chg);
      end
   end
   property p_rate_period;
      @(posedge clk) disable iff (srst)
      (pwm_tick && seen_q && !dirty_q && !sel_chg) |->
         (gap_q == rate_div(pwm_rate_select) - 10'h001);
   endproperty
   a_rate_period: assert property (p_rate_period) else $error("pwm period wrong");
   property p_dac_sync;
      @(posedge clk) disable iff (srst)
      (wr_ok && reg_addr == MOD_CFG_ADDR) |=> (dac_sync == $past(reg_wdata[3]));
   endproperty
   a_dac_sync: assert property (p_dac_sync) else $error("dac sync not written");
   property p_svr;
      @(posedge clk) disable iff (srst)
      (wr_ok && reg_addr == MOD_CFG_ADDR) ##1 !reg_wr |=> (mid_supply_reference == $past(reg_wdata[4], 2));
   endproperty
   a_svr: assert property (p_svr) else $error("reference charge not held");
   property p_gain_hi_read;
      @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == MOD_CFG_ADDR) |=> (reg_rdata[2] == $past(gain_select_hi));
   endproperty
   a_gain_hi_read: assert property (p_gain_hi_read) else $error("gain bit readback");
   property p_strap;
      @(posedge clk) disable iff (srst)
      (st_q == ST_SETTLE && cnt_q == STRAP_SETTLE) |=>
         (gain_select_hi == $past(filt_q[0]) && gain_select_lo == $past(filt_q[1]));
   endproperty
   a_strap: assert property (p_strap) else $error("strap not loaded");
   property p_zc;
      @(posedge clk) disable iff (srst)
      test_q[TST_ZC_BIT] |=> (zero_cross_debug_out ==
         (($past(filt_q[3]) ~^ $past(filt_q[4])) | ($past(filt_q[5]) ~^ $past(filt_q[6]))));
   endproperty
   a_zc: assert property (p_zc) else $error("clip debug mux wrong");
   property p_ramp;
      @(posedge clk) disable iff (srst)
      (test_q[TST_RAMP_BIT] && ctrl_tick) |=> (comp_gain == $past(comp_gain) + 5'h01);
   endproperty
   a_ramp: assert property (p_ramp) else $error("gain ramp stalled");
   property p_gate;
      @(posedge clk) disable iff (srst)
      (wr_ok && reg_addr == TEST_CFG_ADDR) |=> (gate_drive_limit_bypass == $past(reg_wdata[2]));
   endproperty
   a_gate: assert property (p_gate) else $error("gate bypass not written");
   property p_fast;
      @(posedge clk) disable iff (srst)
      ($past(fast_time) && ctrl_tick) |=> ctrl_tick; // Reload under fast gives period one
   endproperty
   a_fast: assert property (p_fast) else $error("fast time base missing");
   property p_unmute;
      @(posedge clk) disable iff (srst)
      $fell(modulator_tristate) |-> unmute_fast ##1 !unmute_fast;
   endproperty
   a_unmute: assert property (p_unmute) else $error("unmute pulse wrong");
   property p_unused_zero;
      @(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == TEST_CFG_ADDR) |=> (reg_rdata[7:4] == 4'h0);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");
   c_tristate_exit: cover property (@(posedge clk) disable iff (srst) $fell(modulator_tristate));
   c_rate_220k: cover property (@(posedge clk) disable iff (srst)
      pwm_tick && pwm_rate_select == 2'h2);
   c_ramp_run: cover property (@(posedge clk) disable iff (srst)
      test_q[TST_RAMP_BIT] && ctrl_tick);

endmodule // amtc_config_regs

// ==== bench/amtc_host_model.sv ====
// Serial front end stand-in that writes and reads the configuration registers.
// Assumes the bench calls its tasks; strobes change on falling clock edges.
`timescale 1ns/10ps
module amtc_host_model (
   input  wire logic       clk,
   output logic      [4:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_addr  = 5'h1F;
      reg_wr    = 1'b0;
      reg_wdata = 8'hA5;
      reg_rd    = 1'b0;
   end

   // One write strobe; data scrambled once the strobe drops
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask

   // One read strobe; data taken a cycle after it
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
endmodule // amtc_host_model

// ==== bench/tb_amtc_config_regs.sv ====
// Self-checking bench for the modulator and test configuration registers.
// Assumes a 40 MHz clock; the host model drives all register strobes.
`timescale 1ns/10ps
module tb_amtc_config_regs import amtc_pkg::*; ;
   typedef struct packed {logic [4:0] a; logic [7:0] w; logic [7:0] r;} amtc_row_s;
   localparam amtc_row_s ROWS [10] = '{'{5'h05, 8'h98, 8'h98}, '{5'h05, 8'h07, 8'h05},
      '{5'h05, 8'h44, 8'h44}, '{5'h05, 8'hE0, 8'hE0}, '{5'h05, 8'h00, 8'h00},
      '{5'h05, 8'hC1, 8'hC1}, '{5'h06, 8'hFF, 8'h0F}, '{5'h06, 8'h08, 8'h08},
      '{5'h06, 8'h04, 8'h04}, '{5'h07, 8'hAA, 8'h00}};
   localparam int PDIV [4] = '{CLK_HZ / PWM_55K_HZ, CLK_HZ / PWM_110K_HZ,
                               CLK_HZ / PWM_220K_HZ, CLK_HZ / PWM_110K_HZ};
   logic       clk, srst, gain_hi_strap_pin, gain_lo_strap_pin, serial_mode_pin;
   logic       neg_input_level, pos_input_level, neg_output_level, pos_output_level;
   logic       clip_normal, reg_wr, reg_rd, pwm_tick, modulator_tristate, dac_sync;
   logic       mid_supply_reference, shunt_on, gain_select_hi, gain_select_lo;
   logic       zero_cross_debug_out, gate_drive_limit_bypass, fast_time, ctrl_tick;
   logic       mute_fast_discharge, unmute_fast;
   logic [1:0] pwm_rate_select;
   logic [3:0] lv;
   logic [4:0] reg_addr, comp_gain_normal, comp_gain;
   logic [7:0] reg_wdata, reg_rdata, rb;
   int         miscompares, checks, cycles, pulses, n;

   amtc_config_regs i_amtc_config_regs (.clk, .srst, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata, .gain_hi_strap_pin, .gain_lo_strap_pin, .serial_mode_pin,
      .neg_input_level, .pos_input_level, .neg_output_level, .pos_output_level,
      .clip_normal, .comp_gain_normal, .pwm_rate_select, .pwm_tick, .modulator_tristate,
      .dac_sync, .mid_supply_reference, .shunt_on, .gain_select_hi, .gain_select_lo,
      .zero_cross_debug_out, .comp_gain, .gate_drive_limit_bypass, .fast_time,
      .ctrl_tick, .mute_fast_discharge, .unmute_fast);
   amtc_host_model i_amtc_host_model (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata);

   // ****************************************************************
   // Clock, watchdog and pulse counter
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         close_out();
      end
   end
   always @(negedge clk) begin
      if (unmute_fast === 1'b1) pulses++;
   end

   // ****************************************************************
   // Compare, measure and closing tasks
   // ****************************************************************
   task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk1(input string s, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic chkn(input string s, input int e, input int g);
      checks++;
      if (g != e) begin
         miscompares++;
         $display("Error %s expected %0d seen %0d", s, e, g);
      end
   endtask
   // Cycles between ticks, after two ticks for alignment
   task automatic period(input bit ctrl, output int p);
      int k;
      for (k = 0; k < 3; k++) begin
         p = 0;
         do begin
            @(negedge clk);
            p++;
         end while (((ctrl ? ctrl_tick : pwm_tick) !== 1'b1) && p < 2000);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      srst = 1'b1;
      {gain_hi_strap_pin, gain_lo_strap_pin, serial_mode_pin} = 3'h3;
      {neg_input_level, pos_input_level, neg_output_level, pos_output_level} = 4'h0;
      clip_normal = 1'b0;
      comp_gain_normal = 5'h0A;
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (10) @(negedge clk);
      i_amtc_host_model.rd(MOD_CFG_ADDR, rb);
      chk8("modulator_config", 8'h41, rb);
      i_amtc_host_model.rd(TEST_CFG_ADDR, rb);
      chk8("test_config", 8'h00, rb);
      chk1("gain_select_lo", 1'b1, gain_select_lo);
      chk1("gain_select_hi", 1'b0, gain_select_hi);
      // Table rows: write, check outputs, read back
      foreach (ROWS[i]) begin
         i_amtc_host_model.wr(ROWS[i].a, ROWS[i].w);
         @(negedge clk);
         if (ROWS[i].a == MOD_CFG_ADDR) begin
            chk8("modulator outputs", ROWS[i].r, {pwm_rate_select, modulator_tristate,
               mid_supply_reference, dac_sync, gain_select_hi, 1'b0, shunt_on});
            chk1("mute_fast_discharge", ROWS[i].r[5], mute_fast_discharge);
         end
         if (ROWS[i].a == TEST_CFG_ADDR) begin
            chk8("test outputs", ROWS[i].r & 8'h0C,
               {4'h0, fast_time, gate_drive_limit_bypass, 2'h0});
         end
         i_amtc_host_model.rd(ROWS[i].a, rb);
         chk8("readback", ROWS[i].r, rb);
      end
      // Leaving tristate gives one unmute pulse
      i_amtc_host_model.wr(MOD_CFG_ADDR, 8'h20);
      i_amtc_host_model.wr(MOD_CFG_ADDR, 8'h20);
      pulses = 0;
      i_amtc_host_model.wr(MOD_CFG_ADDR, 8'h00);
      repeat (4) @(negedge clk);
      chkn("unmute_fast pulses", 1, pulses);
      // Switching period for every rate code
      for (int s = 0; s < 4; s++) begin
         i_amtc_host_model.wr(MOD_CFG_ADDR, {2'(s), 6'h00});
         period(1'b0, n);
         chkn("pwm period", PDIV[s], n);
      end
      i_amtc_host_model.wr(TEST_CFG_ADDR, 8'h00);
      period(1'b1, n);
      chkn("ctrl period", CLK_HZ / CTRL_CLK_HZ, n);
      chk8("comp_gain normal", 8'h0A, {3'h0, comp_gain});
      i_amtc_host_model.wr(TEST_CFG_ADDR, 8'h08);
      period(1'b1, n);
      chkn("ctrl period fast", CLK_HZ / CTRL_CLK_HZ / FAST_FACTOR, n);
      i_amtc_host_model.wr(TEST_CFG_ADDR, 8'h0A);
      @(negedge clk);
      rb = {3'h0, comp_gain};
      @(negedge clk);
      chk8("comp_gain ramp", {3'h0, rb[4:0] + 5'h01}, {3'h0, comp_gain});
      // Clip output for all comparator combinations
      i_amtc_host_model.wr(TEST_CFG_ADDR, 8'h01);
      for (int v = 0; v < 16; v++) begin
         lv = 4'(v);
         {neg_input_level, pos_input_level, neg_output_level, pos_output_level} = lv;
         repeat (10) @(negedge clk);
         chk1("zero_cross_debug_out", (lv[3] ~^ lv[2]) | (lv[1] ~^ lv[0]),
            zero_cross_debug_out);
      end
      i_amtc_host_model.wr(TEST_CFG_ADDR, 8'h00);
      clip_normal = 1'b1;
      repeat (3) @(negedge clk);
      chk1("clip normal", 1'b1, zero_cross_debug_out);
      // Second reset, other straps, write inside settle window
      srst = 1'b1;
      {gain_hi_strap_pin, gain_lo_strap_pin, serial_mode_pin} = 3'h4;
      repeat (16) @(negedge clk);
      srst = 1'b0;
      i_amtc_host_model.wr(MOD_CFG_ADDR, 8'hFF);
      repeat (10) @(negedge clk);
      i_amtc_host_model.rd(MOD_CFG_ADDR, rb);
      chk8("modulator_config strap", 8'h64, rb);
      chk1("gain_select_hi", 1'b1, gain_select_hi);
      chk1("gain_select_lo", 1'b0, gain_select_lo);
      close_out();
   end
endmodule // tb_amtc_config_regs
